// file: logic/dsp_pkg.sv
// Package for the dual-slope PWM counter: register map, fields, reset values and modes.
// Assumes a 32-bit APB slave with one byte register per aligned word.
package dsp_pkg;
  localparam logic [11:0] OFS_CNT_LOW    = 12'h084;
  localparam logic [11:0] OFS_CNT_HIGH   = 12'h088;
  localparam logic [11:0] OFS_CMPA_LOW   = 12'h08C;
  localparam logic [11:0] OFS_CMPA_HIGH  = 12'h090;
  localparam logic [11:0] OFS_CMPB_LOW   = 12'h094;
  localparam logic [11:0] OFS_CMPB_HIGH  = 12'h098;
  localparam logic [11:0] OFS_CAPT_LOW   = 12'h09C;
  localparam logic [11:0] OFS_CAPT_HIGH  = 12'h0A0;
  localparam logic [11:0] OFS_CTRL       = 12'h0A4;
  localparam logic [11:0] OFS_STATUS     = 12'h0A8;
  localparam logic [11:0] OFS_PRESCALE   = 12'h0AC;
  // Control register: waveform mode in [3:0], channel A mode [5:4], channel B mode [7:6].
  localparam int          CTRL_WGM_LSB   = 0;
  localparam int          CTRL_COMA_LSB  = 4;
  localparam int          CTRL_COMB_LSB  = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [7:0]  PRESCALE_RESET = 8'h00;
  localparam logic [15:0] TOP_8BIT       = 16'h00FF;
  localparam logic [15:0] TOP_9BIT       = 16'h01FF;
  localparam logic [15:0] TOP_10BIT      = 16'h03FF;
  localparam logic [3:0]  WGM_PC8        = 4'h1;
  localparam logic [3:0]  WGM_PC9        = 4'h2;
  localparam logic [3:0]  WGM_PC10       = 4'h3;
  localparam logic [3:0]  WGM_PC_CAPT    = 4'hA;
  localparam logic [3:0]  WGM_PC_CMPA    = 4'hB;
  localparam logic [1:0]  COM_OFF        = 2'h0;
  localparam logic [1:0]  COM_NONINV     = 2'h2;
  localparam logic [1:0]  COM_INV        = 2'h3;
endpackage

// file: logic/dsp_prescaler.sv
// Timer clock enable divider for the dual-slope PWM counter.
// Assumes pclk is the only clock; a divide value of zero ticks every cycle.
`timescale 1ns/100ps
module dsp_prescaler
  import dsp_pkg::*;
(
  input  wire logic       pclk,     // System clock.
  input  wire logic       presetn,  // Asynchronous reset, active low.
  input  wire logic [7:0] divide,   // Ticks every divide+1 cycles.
  output logic            tick      // One-cycle timer clock enable.
);
  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } dsp_pre_state_t;

  dsp_pre_state_t st;
  dsp_pre_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count >= divide) begin
      next_st.count = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// file: logic/dsp_compare_out.sv
// One compare output channel of the dual-slope PWM counter.
// Assumes match and direction come from the counter core, qualified by the timer tick.
`timescale 1ns/100ps
module dsp_compare_out
  import dsp_pkg::*;
(
  input  wire logic       pclk,      // System clock.
  input  wire logic       presetn,   // Asynchronous reset, active low.
  input  wire logic       match,     // Counter equals compare value on a tick.
  input  wire logic       counting_up, // Count direction at the match.
  input  wire logic [1:0] mode_wr,   // Output mode as last written by software.
  output logic            pin        // Compare output pin level.
);
  typedef struct packed {
    logic pin;
  } dsp_cmp_state_t;

  dsp_cmp_state_t st;
  dsp_cmp_state_t next_st;

  always_comb begin
    next_st = st;
    // The mode is looked at only at a match, so a new setting first acts there and never glitches the pin.
    if (match) begin
      case (mode_wr)
        COM_NONINV: next_st.pin = ~counting_up;
        COM_INV:    next_st.pin = counting_up;
        default:    next_st.pin = st.pin;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin = st.pin;

  pin_hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    match && mode_wr == COM_OFF |=> $stable(pin))
    else $error("pin moved with mode off");
  pin_noninv_a: assert property (@(posedge pclk) disable iff (!presetn)
    match && mode_wr == COM_NONINV |=> pin == !$past(counting_up))
    else $error("bad noninv level");
  pin_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    match && mode_wr == COM_INV |=> pin == $past(counting_up))
    else $error("bad inv level");
  pin_nomatch_a: assert property (@(posedge pclk) disable iff (!presetn)
    !match |=> $stable(pin))
    else $error("pin moved without match");
endmodule

// file: logic/dsp_pwm_counter.sv
// Dual-slope phase correct PWM counter with an APB register file and two compare pins.
// Assumes an APB master on pclk; registers are bytes in the low bits of aligned words.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
// Contract
// - Phase correct dual-slope mode runs for waveform codes 1, 2, 3, A and B.
// - Counter climbs from zero to TOP, then falls back to zero, repeatedly.
// - Non-inverting: clear output on up-count match, set on down-count match.
// - Inverting: set output on up-count match, clear on down-count match.
// - Codes 1, 2, 3 use fixed TOP of 0x00FF, 0x01FF, 0x03FF.
// - Code A takes TOP from capture value, code B from channel A compare.
// - At TOP the counter holds one timer tick, then counts down.
// - Counter readable and writable as separate high and low byte locations.
// - High byte goes through an 8-bit holding latch for atomic access.
// - One holding latch is shared by every 16-bit timer register.
// - A counter write blocks compare matches on the next timer tick.
// - Output mode zero means no action on that pin at matches.
// - A new output mode takes effect at the first match after writing.
module dsp_pwm_counter
  import dsp_pkg::*;
(
  input  wire logic        pclk,     // System clock, 50 MHz.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB access phase.
  input  wire logic        pwrite,   // APB write when high.
  input  wire logic [11:0] paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic             pready,   // APB ready.
  output logic [31:0]      prdata,   // APB read data.
  output logic             pslverr,  // APB error for unmapped addresses.
  output logic             pin_a,    // Channel A compare output pin.
  output logic             pin_b     // Channel B compare output pin.
);
  typedef struct packed {
    logic [15:0] count;
    logic        counting_up;
    logic        block_match;
    logic [7:0]  hold_latch;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capt;
    logic [7:0]  ctrl;
    logic [7:0]  prescale;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dsp_core_state_t;

  dsp_core_state_t st;
  dsp_core_state_t next_st;

  logic        tick;
  logic [3:0]  wgm;
  logic        pc_mode;
  logic [15:0] top;
  logic        access;
  logic        wr;
  logic        rd;
  logic        cnt_written;
  logic [7:0]  wbyte;
  logic [1:0]  match_hit;
  logic [15:0] cmp_val [2];

  assign wgm = st.ctrl[CTRL_WGM_LSB +: 4];
  assign pc_mode = (wgm == WGM_PC8) || (wgm == WGM_PC9) || (wgm == WGM_PC10) ||
                   (wgm == WGM_PC_CAPT) || (wgm == WGM_PC_CMPA);
  assign access = psel && penable && !st.pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wbyte = pwdata[7:0];
  assign cnt_written = wr && (paddr == OFS_CNT_LOW);
  assign cmp_val[0] = st.cmp_a;
  assign cmp_val[1] = st.cmp_b;

  always_comb begin
    if (wgm == WGM_PC8) begin
      top = TOP_8BIT;
    end else if (wgm == WGM_PC9) begin
      top = TOP_9BIT;
    end else if (wgm == WGM_PC10) begin
      top = TOP_10BIT;
    end else if (wgm == WGM_PC_CAPT) begin
      top = st.capt;
    end else begin
      top = st.cmp_a;
    end
  end

  // Matches are qualified by the tick and the blocking flag set by a counter write.
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_match
      assign match_hit[ch] = tick && pc_mode && !st.block_match && (st.count == cmp_val[ch]);
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // Counter engine.
    if (tick) begin
      next_st.block_match = 1'b0;
      if (pc_mode) begin
        if (st.counting_up) begin
          if (st.count >= top) begin
            // TOP has already stood for one whole tick period, so this tick steps down at once.
            // A TOP lowered below the counter by software turns it here instead of letting it wrap.
            next_st.counting_up = 1'b0;
            next_st.count = (top == 16'h0000) ? top : top - 16'h0001;
          end else begin
            next_st.count = st.count + 16'h0001;
          end
        end else begin
          if (st.count == 16'h0000) begin
            next_st.counting_up = 1'b1;
            next_st.count = 16'h0001;
          end else begin
            next_st.count = st.count - 16'h0001;
          end
        end
      end
    end
    // APB slave; a new access is answered in the cycle after the access phase opens.
    if (access) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      if (paddr == OFS_CNT_LOW) begin
        if (wr) begin
          next_st.count = {st.hold_latch, wbyte};
          next_st.block_match = 1'b1;
        end else begin
          next_st.prdata = {24'h000000, st.count[7:0]};
          next_st.hold_latch = st.count[15:8];
        end
      end else if (paddr == OFS_CNT_HIGH || paddr == OFS_CMPA_HIGH ||
                   paddr == OFS_CMPB_HIGH || paddr == OFS_CAPT_HIGH) begin
        if (wr) begin
          next_st.hold_latch = wbyte;
        end else begin
          next_st.prdata = {24'h000000, st.hold_latch};
        end
      end else if (paddr == OFS_CMPA_LOW) begin
        if (wr) begin
          next_st.cmp_a = {st.hold_latch, wbyte};
        end else begin
          next_st.prdata = {24'h000000, st.cmp_a[7:0]};
          next_st.hold_latch = st.cmp_a[15:8];
        end
      end else if (paddr == OFS_CMPB_LOW) begin
        if (wr) begin
          next_st.cmp_b = {st.hold_latch, wbyte};
        end else begin
          next_st.prdata = {24'h000000, st.cmp_b[7:0]};
          next_st.hold_latch = st.cmp_b[15:8];
        end
      end else if (paddr == OFS_CAPT_LOW) begin
        if (wr) begin
          next_st.capt = {st.hold_latch, wbyte};
        end else begin
          next_st.prdata = {24'h000000, st.capt[7:0]};
          next_st.hold_latch = st.capt[15:8];
        end
      end else if (paddr == OFS_CTRL) begin
        if (wr) begin
          next_st.ctrl = wbyte;
        end else begin
          next_st.prdata = {24'h000000, st.ctrl};
        end
      end else if (paddr == OFS_STATUS) begin
        // Status is read-only; a write to it is answered normally and ignored.
        if (rd) begin
          next_st.prdata = {29'h0, st.counting_up, pin_b, pin_a};
        end
      end else if (paddr == OFS_PRESCALE) begin
        if (wr) begin
          next_st.prescale = wbyte;
        end else begin
          next_st.prdata = {24'h000000, st.prescale};
        end
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.counting_up <= 1'b1;
      st.count <= CNT_RESET;
      st.ctrl <= CTRL_RESET;
      st.prescale <= PRESCALE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;

  dsp_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .divide  (st.prescale),
    .tick    (tick)
  );

  dsp_compare_out u_out_a (
    .pclk        (pclk),
    .presetn     (presetn),
    .match       (match_hit[0]),
    .counting_up (st.counting_up),
    .mode_wr     (st.ctrl[CTRL_COMA_LSB +: 2]),
    .pin         (pin_a)
  );

  dsp_compare_out u_out_b (
    .pclk        (pclk),
    .presetn     (presetn),
    .match       (match_hit[1]),
    .counting_up (st.counting_up),
    .mode_wr     (st.ctrl[CTRL_COMB_LSB +: 2]),
    .pin         (pin_b)
  );

  // Assertion helpers. A counter write stays pending until the timer tick that it must blank.
  logic blk_pend;
  logic addr_known;

  assign addr_known = paddr inside {OFS_CNT_LOW, OFS_CNT_HIGH, OFS_CMPA_LOW, OFS_CMPA_HIGH, OFS_CMPB_LOW,
                                    OFS_CMPB_HIGH, OFS_CAPT_LOW, OFS_CAPT_HIGH, OFS_CTRL, OFS_STATUS,
                                    OFS_PRESCALE};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_pend <= 1'b0;
    end else if (cnt_written) begin
      blk_pend <= 1'b1;
    end else if (tick) begin
      blk_pend <= 1'b0;
    end
  end

  sequence s_cnt_write;
    cnt_written;
  endsequence

  sequence s_apb_take;
    access;
  endsequence

  // Only ticks without a bus access in the same cycle, so that the engine alone moves the counter.
  sequence s_quiet_tick;
    tick && pc_mode && !access;
  endsequence

  sequence s_up_at_top;
    s_quiet_tick ##0 (st.counting_up && st.count == top && top != 16'h0000);
  endsequence

  // Counter engine.
  count_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_quiet_tick ##0 (st.counting_up && st.count < top) |=> st.count == $past(st.count) + 16'h0001)
    else $error("count did not rise");
  count_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_quiet_tick ##0 (!st.counting_up && st.count != 16'h0000) |=> st.count == $past(st.count) - 16'h0001)
    else $error("count did not fall");
  top_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top |=> st.count == $past(st.count) - 16'h0001 && !st.counting_up)
    else $error("no turn at top");
  floor_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_quiet_tick ##0 (!st.counting_up && st.count == 16'h0000) |=> st.counting_up && st.count == 16'h0001)
    else $error("no turn at floor");
  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !pc_mode && !access |=> $stable(st.count))
    else $error("counter ran outside mode");
  mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pc_mode |-> match_hit == 2'b00)
    else $error("match outside mode");
  match_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    blk_pend && tick |-> match_hit == 2'b00)
    else $error("match not blocked");

  // TOP per mode, seen where the counter turns.
  fixed_top8_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top ##0 wgm == WGM_PC8 |=> st.count == TOP_8BIT - 16'h0001)
    else $error("wrong 8-bit top");
  fixed_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top ##0 wgm == WGM_PC9 |=> st.count == TOP_9BIT - 16'h0001)
    else $error("wrong 9-bit top");
  fixed_top10_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top ##0 wgm == WGM_PC10 |=> st.count == TOP_10BIT - 16'h0001)
    else $error("wrong 10-bit top");
  capt_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top ##0 wgm == WGM_PC_CAPT |=> st.count == $past(st.capt) - 16'h0001)
    else $error("wrong capture top");
  reg_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_at_top ##0 wgm == WGM_PC_CMPA |=> st.count == $past(st.cmp_a) - 16'h0001)
    else $error("wrong register top");

  // Byte access through the shared holding latch.
  atomic_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_cnt_write |=> st.count == {$past(st.hold_latch), $past(wbyte)})
    else $error("counter write not atomic");
  read_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFS_CNT_LOW |=> st.hold_latch == $past(st.count[15:8]))
    else $error("latch not loaded");
  low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFS_CNT_LOW |=> prdata == {24'h000000, $past(st.count[7:0])})
    else $error("bad counter low byte");
  latch_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_CMPB_HIGH |=> st.hold_latch == $past(wbyte))
    else $error("high byte not latched");
  cmpa_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_CMPA_LOW |=> st.cmp_a == {$past(st.hold_latch), $past(wbyte)})
    else $error("compare write not atomic");
  latch_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFS_CAPT_HIGH |=> prdata == {24'h000000, $past(st.hold_latch)})
    else $error("high byte not from latch");

  // Bus answer and plain registers.
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_take |=> pready)
    else $error("access not answered");
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_take ##0 !addr_known |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_take ##0 addr_known |=> !pslverr)
    else $error("mapped access refused");
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_CTRL |=> st.ctrl == $past(wbyte))
    else $error("control write lost");
  prescale_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_PRESCALE |=> st.prescale == $past(wbyte))
    else $error("prescale write lost");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFS_STATUS |=> prdata == {29'h0, $past(st.counting_up), $past(pin_b), $past(pin_a)})
    else $error("bad status read");
endmodule

// file: dv/dsp_pwm_counter_tb.sv
// Self-checking bench for the dual-slope PWM counter: APB access, byte latch, TOP per mode, pin timing.
// Assumes one wait state on APB and a timer tick every prescale+1 clocks, as the design promises.
`timescale 1ns/100ps
module dsp_pwm_counter_tb;
  import dsp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  logic [31:0] rd_data;
  logic        rd_err;
  int          num_errors;
  int          samples_checked;

  dsp_pwm_counter dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .pin_a   (pin_a),
    .pin_b   (pin_b)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Response is captured on the falling edge because pslverr stands for one cycle only.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      rd_data = prdata;
      rd_err  = pslverr;
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
    end
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // High byte first so that the low byte write commits both through the shared latch.
  task automatic wr16(input logic [11:0] hi, input logic [15:0] val);
    apb(1'b1, hi, {24'h0, val[15:8]});
    apb(1'b1, hi - 12'h004, {24'h0, val[7:0]});
  endtask

  task automatic rd16(input logic [11:0] hi, output logic [15:0] val);
    logic [7:0] lo;
    apb(1'b0, hi - 12'h004, 32'h0);
    lo = rd_data[7:0];
    apb(1'b0, hi, 32'h0);
    val = {rd_data[7:0], lo};
  endtask

  task automatic wait_pin_b(input logic lvl);
    int n;
    n = 0;
    while (pin_b !== lvl && n < 9000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 9000) begin
      chk("pin_b wait", {31'h0, lvl}, {31'h0, pin_b});
    end
  endtask

  task automatic count_level(input logic lvl, output int n);
    n = 0;
    while (pin_b === lvl && n < 9000) begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic test_reset();
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    chk("counter low reset", {24'h0, CNT_RESET[7:0]}, rd_data);
    chk("pslverr mapped", 32'h0, {31'h0, rd_err});
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RESET}, rd_data);
    apb(1'b0, OFS_PRESCALE, 32'h0);
    chk("prescale reset", {24'h0, PRESCALE_RESET}, rd_data);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0000_0004, rd_data);
    chk("pins reset", 32'h0, {30'h0, pin_a, pin_b});
    apb(1'b1, 12'h0FC, 32'h0000_00FF);
    chk("pslverr unmapped", 32'h1, {31'h0, rd_err});
  endtask

  task automatic test_latch();
    logic [15:0] v;
    wr16(OFS_CNT_HIGH, 16'h1234);
    repeat (5) @(posedge pclk);
    rd16(OFS_CNT_HIGH, v);
    chk("counter word", 32'h0000_1234, {16'h0, v});
    apb(1'b1, OFS_CNT_HIGH, 32'h0000_00AB);
    apb(1'b1, OFS_CMPA_LOW, 32'h0000_00CD);
    rd16(OFS_CMPA_HIGH, v);
    chk("latch shared", 32'h0000_ABCD, {16'h0, v});
  endtask

  task automatic run_mode(input logic [3:0] wgm, input logic [15:0] top, input logic [15:0] c, input logic [7:0] div);
    int hi;
    int lo;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_PRESCALE, {24'h0, div});
    // The counter is loaded while the mode is off, so no compare match can be lost.
    wr16(OFS_CNT_HIGH, 16'h0000);
    wr16(OFS_CAPT_HIGH, top);
    wr16(OFS_CMPA_HIGH, (wgm == WGM_PC_CMPA) ? top : c);
    wr16(OFS_CMPB_HIGH, c);
    apb(1'b1, OFS_CTRL, {24'h0, COM_NONINV, COM_INV, wgm});
    wait_pin_b(1'b0);
    wait_pin_b(1'b1);
    if (wgm != WGM_PC_CMPA) begin
      chk("pin_a inverted", 32'h0, {31'h0, pin_a});
    end
    count_level(1'b1, hi);
    count_level(1'b0, lo);
    chk("high time", 2 * c * (div + 1), 32'(hi));
    chk("low time", 2 * (top - c) * (div + 1), 32'(lo));
  endtask

  task automatic test_block_match();
    int n;
    run_mode(WGM_PC8, TOP_8BIT, 16'h0010, 8'h00);
    wait_pin_b(1'b0);
    repeat (259) @(negedge pclk);
    wr16(OFS_CNT_HIGH, 16'h0010);
    n = 0;
    repeat (20) begin
      @(negedge pclk);
      n += int'(pin_b === 1'b1);
    end
    chk("blocked match", 32'h0, 32'(n));
  endtask

  task automatic test_mode_off();
    int n;
    logic lvl;
    apb(1'b1, OFS_CTRL, {24'h0, COM_OFF, COM_NONINV, WGM_PC8});
    @(negedge pclk);
    lvl = pin_b;
    n = 0;
    repeat (520) begin
      @(negedge pclk);
      n += int'(pin_b !== lvl);
    end
    chk("pin_b idle", 32'h0, 32'(n));
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  initial begin
    num_errors      = 0;
    samples_checked = 0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_latch();
    run_mode(WGM_PC8, TOP_8BIT, 16'h0010, 8'h00);
    run_mode(WGM_PC9, TOP_9BIT, 16'h0100, 8'h00);
    run_mode(WGM_PC10, TOP_10BIT, 16'h0005, 8'h00);
    run_mode(WGM_PC_CAPT, 16'h0040, 16'h0010, 8'h02);
    run_mode(WGM_PC_CMPA, 16'h0003, 16'h0001, 8'h00);
    test_block_match();
    test_mode_off();
    print_verdict();
  end
endmodule
